// File: logic/pipe_ctrl_pkg.sv
// Shared constants and types for the dual-pipe hazard and branch control block
package pipe_ctrl_pkg;
	localparam int ADDR_W      = 32;
	localparam int DATA_W      = 32;
	localparam int REG_W       = 5;
	localparam int TABLE_SETS  = 64;
	localparam int TABLE_WAYS  = 4;
	localparam int TABLE_SIZE  = 256;
	localparam int STACK_DEPTH = 8;
	localparam int SET_W       = 6;
	localparam int TAG_W       = ADDR_W - SET_W - 2;
	localparam int LAT_EXEC    = 4;
	localparam int LAT_WBACK   = 5;
	localparam int BYPASS_STALL = 1;
	localparam logic [2:0] LAT_EXEC_CNT  = 3'h4;
	localparam logic [2:0] LAT_WBACK_CNT = 3'h5;
	localparam logic [1:0] HIST_RESET = 2'h1;
	localparam logic [1:0] HIST_ALLOC = 2'h2;
	localparam logic [ADDR_W-1:0] FETCH_STEP = 32'h0000_0004;

	// Operation class of a decoded instruction
	typedef enum logic [2:0] {
		OP_NONE  = 3'b000,
		OP_MOVE  = 3'b001,
		OP_ALU   = 3'b010,
		OP_BRCND = 3'b011,
		OP_BRUNC = 3'b100,
		OP_CALL  = 3'b101,
		OP_RET   = 3'b110
	} op_e;

	// Operand width code
	typedef enum logic [1:0] {
		SZ_8  = 2'b00,
		SZ_16 = 2'b01,
		SZ_32 = 2'b10
	} size_e;

	// One issued instruction as seen by hazard logic
	typedef struct packed {
		logic              valid;
		op_e               op;
		logic              src_mem;
		logic              dst_mem;
		logic [REG_W-1:0]  src_reg;
		logic [REG_W-1:0]  dst_reg;
		logic [ADDR_W-1:0] mem_addr;
		size_e             src_size;
		size_e             dst_size;
		logic              sets_flags;
	} instr_s;
endpackage

// File: logic/target_if.sv
// Lookup and update channel between control logic and the target table
`timescale 1ns/1ps
`default_nettype none
interface target_if;
	import pipe_ctrl_pkg::*;
	logic [ADDR_W-1:0] look_pc;
	logic              hit;
	logic [ADDR_W-1:0] hit_target;
	logic [1:0]        hit_hist;
	logic              upd_valid;
	logic [ADDR_W-1:0] upd_pc;
	logic [ADDR_W-1:0] upd_target;
	logic              upd_taken;
	modport ctrl  (output look_pc, upd_valid, upd_pc, upd_target, upd_taken,
		input hit, hit_target, hit_hist);
	modport table_side (input look_pc, upd_valid, upd_pc, upd_target, upd_taken,
		output hit, hit_target, hit_hist);
endinterface
`default_nettype wire

// File: logic/branch_target_table.sv
// Set-associative branch target table with four-state history counters
`timescale 1ns/1ps
`default_nettype none
module branch_target_table (
	input  wire logic i_clk,
	input  wire logic i_rst,
	target_if.table_side tif
);
	import pipe_ctrl_pkg::*;

	logic              vld [TABLE_SETS][TABLE_WAYS];
	logic [TAG_W-1:0]  tag [TABLE_SETS][TABLE_WAYS];
	logic [ADDR_W-1:0] tgt [TABLE_SETS][TABLE_WAYS];
	logic [1:0]        hist[TABLE_SETS][TABLE_WAYS];
	logic [1:0]        victim[TABLE_SETS];
	logic              hit;
	logic [ADDR_W-1:0] hit_target;
	logic [1:0]        hit_hist;
	logic              upd_found;
	logic [1:0]        upd_way;
	logic [SET_W-1:0]  upd_set;

	function automatic logic [SET_W-1:0] set_of(input logic [ADDR_W-1:0] pc);
		return pc[SET_W+1:2];
	endfunction
	function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] pc);
		return pc[ADDR_W-1:SET_W+2];
	endfunction

	// Combinational lookup, read result registered in the control block
	always_comb begin
		hit = 1'b0;
		hit_target = '0;
		hit_hist = '0;
		for (int w = 0; w < TABLE_WAYS; w++) begin
			if (vld[set_of(tif.look_pc)][w] && tag[set_of(tif.look_pc)][w] == tag_of(tif.look_pc)) begin
				hit = 1'b1;
				hit_target = tgt[set_of(tif.look_pc)][w];
				hit_hist = hist[set_of(tif.look_pc)][w];
			end
		end
	end
	assign tif.hit = hit;
	assign tif.hit_target = hit_target;
	assign tif.hit_hist = hit_hist;

	// Way that already holds the resolving branch
	always_comb begin
		upd_set = set_of(tif.upd_pc);
		upd_found = 1'b0;
		upd_way = 2'h0;
		for (int w = 0; w < TABLE_WAYS; w++) begin
			if (vld[upd_set][w] && tag[upd_set][w] == tag_of(tif.upd_pc)) begin
				upd_found = 1'b1;
				upd_way = 2'(w);
			end
		end
	end

	// History update on resolve, allocation of taken misses
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int s = 0; s < TABLE_SETS; s++) begin
				victim[s] <= 2'h0;
				for (int w = 0; w < TABLE_WAYS; w++) begin
					vld[s][w] <= 1'b0;
					tag[s][w] <= '0;
					tgt[s][w] <= '0;
					hist[s][w] <= HIST_RESET;
				end
			end
		end else if (tif.upd_valid) begin
			if (upd_found) begin
				// Only a taken outcome carries a real target
				if (tif.upd_taken) tgt[upd_set][upd_way] <= tif.upd_target;
				if (tif.upd_taken && hist[upd_set][upd_way] != 2'h3) begin
					hist[upd_set][upd_way] <= hist[upd_set][upd_way] + 2'h1; // RQ24
				end
				if (!tif.upd_taken && hist[upd_set][upd_way] != 2'h0) begin
					hist[upd_set][upd_way] <= hist[upd_set][upd_way] - 2'h1; // RQ24
				end
			end else if (tif.upd_taken) begin
				vld[upd_set][victim[upd_set]] <= 1'b1; // RQ24
				tag[upd_set][victim[upd_set]] <= tag_of(tif.upd_pc);
				tgt[upd_set][victim[upd_set]] <= tif.upd_target;
				hist[upd_set][victim[upd_set]] <= HIST_ALLOC;
				victim[upd_set] <= victim[upd_set] + 2'h1;
			end
		end
	end

	initial assert (TABLE_SETS * TABLE_WAYS == TABLE_SIZE); // RQ10
endmodule
`default_nettype wire

// File: logic/dual_pipe_ctrl.sv
// Hazard resolution, branch prediction and return stack for the paired pipes
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// RQ1 - Move pair: one read feeds both instructions
// RQ2 - Operand forward only after non-modifying move
// RQ3 - Register or memory operands, widths must match
// RQ4 - Compute then move: write both destinations
// RQ5 - Result forward only when second is move
// RQ6 - Operand forwarded pair runs without stall
// RQ7 - Store then load same address: bypass data
// RQ8 - Bypass only for cacheable addresses
// RQ9 - Bypass pair stalls secondary exactly one clock
// RQ10 - Target table: 256 entries, four ways
// RQ11 - Unconditional hit redirects fetch to target
// RQ12 - Conditional hit uses four-state history
// RQ13 - Conditional miss predicts not taken
// RQ14 - Conditional branches go to primary only
// RQ15 - Resolve in execute or writeback by flags
// RQ16 - Correct prediction adds no bubbles
// RQ17 - Mispredict flushes and refetches correct target
// RQ18 - Prefetch both predicted and alternate paths
// RQ19 - Mispredict cost four or five cycles
// RQ20 - Returns predicted from eight-entry stack
// RQ21 - Call pushes, return pops address
// RQ22 - In-order before execute stage
// RQ23 - Branch may pair with secondary instruction
// RQ24 - Resolve updates history, allocates taken misses
// RQ25 - Full push overwrites oldest, empty pop falls back
module dual_pipe_ctrl (
	input  wire logic                               i_clk,
	input  wire logic                               i_rst,
	input  wire pipe_ctrl_pkg::instr_s              i_pri,
	input  wire pipe_ctrl_pkg::instr_s              i_sec,
	input  wire logic                               i_cacheable,
	input  wire logic [pipe_ctrl_pkg::ADDR_W-1:0]   i_fetch_pc,
	input  wire pipe_ctrl_pkg::op_e                 i_fetch_op,
	input  wire logic [pipe_ctrl_pkg::ADDR_W-1:0]   i_fetch_target,
	input  wire logic                               i_res_valid,
	input  wire logic [pipe_ctrl_pkg::ADDR_W-1:0]   i_res_pc,
	input  wire logic                               i_res_taken,
	input  wire logic [pipe_ctrl_pkg::ADDR_W-1:0]   i_res_target,
	input  wire logic                               i_res_predicted,
	input  wire logic                               i_res_flags_paired,
	output logic                                    o_operand_fwd,
	output logic                                    o_result_fwd,
	output logic                                    o_bypass,
	output logic                                    o_sec_stall,
	output logic                                    o_sec_is_branch,
	output logic [pipe_ctrl_pkg::ADDR_W-1:0]        o_next_pc,
	output logic [pipe_ctrl_pkg::ADDR_W-1:0]        o_alt_pc,
	output logic                                    o_pred_taken,
	output logic                                    o_flush,
	output logic                                    o_resolve_wb,
	output logic                                    o_fetch_hold
);
	import pipe_ctrl_pkg::*;

	typedef enum logic [1:0] {
		RUN  = 2'b00,
		HOLD = 2'b01
	} recov_e;

	target_if tif ();

	branch_target_table u_table (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.tif   (tif)
	);

	// Pair classification helpers
	function automatic logic is_move(input op_e op);
		return op == OP_MOVE;
	endfunction
	function automatic logic dep_on(input instr_s a, input instr_s b);
		return a.dst_mem ? (b.src_mem && a.mem_addr == b.mem_addr)
			: (!b.src_mem && a.dst_reg == b.src_reg);
	endfunction

	logic operand_fwd, next_operand_fwd;
	logic result_fwd,  next_result_fwd;
	logic bypass,      next_bypass;
	logic sec_stall,   next_sec_stall;
	logic sec_is_branch, next_sec_is_branch;
	logic sec_brcnd;

	// Forwarding and bypass decision for the issued pair
	always_comb begin
		next_operand_fwd = 1'b0;
		next_result_fwd = 1'b0;
		next_bypass = 1'b0;
		next_sec_stall = 1'b0;
		sec_brcnd = i_sec.valid && i_sec.op == OP_BRCND;
		next_sec_is_branch = sec_brcnd; // RQ14
		// A conditional branch never pairs from the secondary slot
		if (i_pri.valid && i_sec.valid && !sec_brcnd) begin // RQ23
			if (is_move(i_pri.op) && dep_on(i_pri, i_sec)
				&& i_pri.dst_size == i_sec.src_size) begin
				next_operand_fwd = 1'b1; // RQ1 RQ2 RQ3 RQ6
			end else if (i_pri.op == OP_ALU && is_move(i_sec.op) && !i_pri.dst_mem
				&& !i_sec.src_mem && i_pri.dst_reg == i_sec.src_reg) begin
				next_result_fwd = 1'b1; // RQ4 RQ5
			end else if (i_pri.dst_mem && i_sec.src_mem && i_pri.mem_addr == i_sec.mem_addr
				&& i_cacheable) begin
				next_bypass = 1'b1; // RQ7 RQ8
			end
		end
		// One clock hold for a bypass pair; a held branch waits for the primary pipe
		next_sec_stall = (next_bypass && !bypass) || sec_brcnd; // RQ9 RQ14
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			operand_fwd <= 1'b0;
			result_fwd <= 1'b0;
			bypass <= 1'b0;
			sec_stall <= 1'b0;
			sec_is_branch <= 1'b0;
		end else begin
			operand_fwd <= next_operand_fwd;
			result_fwd <= next_result_fwd;
			bypass <= next_bypass;
			sec_stall <= next_sec_stall;
			sec_is_branch <= next_sec_is_branch;
		end
	end

	// Return-address stack state
	logic [ADDR_W-1:0] stack [STACK_DEPTH];
	logic [ADDR_W-1:0] next_stack [STACK_DEPTH];
	logic [3:0] depth, next_depth;
	logic [ADDR_W-1:0] next_pc, next_next_pc, alt_pc, next_alt_pc;
	logic pred_taken, next_pred_taken;

	// Table lookup follows the fetch address
	assign tif.look_pc = i_fetch_pc;

	// Fetch-side prediction and stack push/pop
	always_comb begin
		next_stack = stack;
		next_depth = depth;
		next_next_pc = i_fetch_pc + FETCH_STEP;
		next_alt_pc = i_fetch_pc + FETCH_STEP;
		next_pred_taken = 1'b0;
		unique case (i_fetch_op)
			OP_BRUNC: begin
				if (tif.hit) begin
					next_next_pc = tif.hit_target; // RQ11
					next_pred_taken = 1'b1;
				end
			end
			OP_BRCND: begin
				next_alt_pc = tif.hit ? tif.hit_target : i_fetch_target; // RQ18
				if (tif.hit && tif.hit_hist[1]) begin
					next_next_pc = tif.hit_target; // RQ12
					next_alt_pc = i_fetch_pc + FETCH_STEP;
					next_pred_taken = 1'b1;
				end
				// Miss keeps sequential path RQ13
			end
			OP_CALL: begin
				next_next_pc = i_fetch_target;
				next_pred_taken = 1'b1;
				for (int i = STACK_DEPTH - 1; i > 0; i--) next_stack[i] = stack[i-1]; // RQ25
				next_stack[0] = i_fetch_pc + FETCH_STEP; // RQ21
				if (depth != 4'(STACK_DEPTH)) next_depth = depth + 4'h1;
			end
			OP_RET: begin
				if (depth != 4'h0) begin
					next_next_pc = stack[0]; // RQ20 RQ21
					next_pred_taken = 1'b1;
					for (int i = 0; i < STACK_DEPTH - 1; i++) next_stack[i] = stack[i+1];
					next_depth = depth - 4'h1;
				end else if (tif.hit) begin
					next_next_pc = tif.hit_target; // RQ25
					next_pred_taken = 1'b1;
				end
			end
			default: begin
				next_next_pc = i_fetch_pc + FETCH_STEP;
			end
		endcase
	end

	// Resolution, flush and recovery counting
	recov_e state, next_state;
	logic [2:0] cnt, next_cnt;
	logic flush, next_flush;
	logic resolve_wb, next_resolve_wb;
	logic fetch_hold, next_fetch_hold;
	logic mispredict;
	logic redirect;

	always_comb begin
		mispredict = i_res_valid && (i_res_taken != i_res_predicted);
		redirect = mispredict && state == RUN;
		next_state = state;
		next_cnt = cnt;
		next_flush = 1'b0;
		next_resolve_wb = i_res_valid && i_res_flags_paired; // RQ15
		next_fetch_hold = fetch_hold;
		// Resolutions inside a hold belong to flushed work
		tif.upd_valid = i_res_valid && state == RUN; // RQ24
		tif.upd_pc = i_res_pc;
		tif.upd_target = i_res_target;
		tif.upd_taken = i_res_taken;
		unique case (state)
			RUN: begin
				if (mispredict) begin
					next_flush = 1'b1; // RQ17
					next_state = HOLD;
					next_fetch_hold = 1'b1;
					// Penalty counted from resolution RQ19
					next_cnt = i_res_flags_paired ? LAT_WBACK_CNT : LAT_EXEC_CNT;
				end
			end
			HOLD: begin
				next_cnt = cnt - 3'h1;
				if (cnt == 3'h1) begin
					next_state = RUN;
					next_fetch_hold = 1'b0;
				end
			end
			default: begin
				next_state = RUN;
				next_fetch_hold = 1'b0;
			end
		endcase
		// Correct predictions never assert hold RQ16
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= RUN;
			cnt <= 3'h0;
			flush <= 1'b0;
			resolve_wb <= 1'b0;
			fetch_hold <= 1'b0;
			depth <= 4'h0;
			next_pc <= '0;
			alt_pc <= '0;
			pred_taken <= 1'b0;
			for (int i = 0; i < STACK_DEPTH; i++) stack[i] <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			flush <= next_flush;
			resolve_wb <= next_resolve_wb;
			fetch_hold <= next_fetch_hold;
			depth <= next_depth;
			stack <= next_stack;
			// Flush redirect overrides prediction
			next_pc <= redirect ? (i_res_taken ? i_res_target : i_res_pc + FETCH_STEP)
				: next_next_pc; // RQ17 RQ22
			alt_pc <= next_alt_pc;
			pred_taken <= redirect ? 1'b0 : next_pred_taken;
		end
	end

	assign o_operand_fwd = operand_fwd;
	assign o_result_fwd = result_fwd;
	assign o_bypass = bypass;
	assign o_sec_stall = sec_stall;
	assign o_sec_is_branch = sec_is_branch;
	assign o_next_pc = next_pc;
	assign o_alt_pc = alt_pc;
	assign o_pred_taken = pred_taken;
	assign o_flush = flush;
	assign o_resolve_wb = resolve_wb;
	assign o_fetch_hold = fetch_hold;

	// Checks
	operand_nostall_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ6
		o_operand_fwd |-> !o_sec_stall) else $error("stall on forwarded pair");
	bypass_cache_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ8
		o_bypass |-> $past(i_cacheable)) else $error("bypass on uncached");
	bypass_stall_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ9
		$rose(o_bypass) |-> o_sec_stall) else $error("bypass stall missing");
	one_stall_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ9
		(o_sec_stall && !o_sec_is_branch) |=> (!o_sec_stall || o_sec_is_branch))
		else $error("stall too long");
	sec_branch_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ14
		o_sec_is_branch |-> o_sec_stall) else $error("branch in secondary pipe");
	flush_exec_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ19
		(o_flush && !o_resolve_wb) |-> o_fetch_hold [*4] ##1 !o_fetch_hold)
		else $error("execute penalty wrong");
	flush_wb_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ19
		(o_flush && o_resolve_wb) |-> o_fetch_hold [*5] ##1 !o_fetch_hold)
		else $error("writeback penalty wrong");
	good_pred_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ16
		(i_res_valid && i_res_taken == i_res_predicted && !fetch_hold) |=> !o_flush)
		else $error("flush on correct prediction");
	stack_depth_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ25
		depth <= 4'(STACK_DEPTH)) else $error("stack overflow");
	operand_move_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ2 RQ3
		o_operand_fwd |-> ($past(i_pri.op) == OP_MOVE
		&& $past(i_pri.dst_size == i_sec.src_size)))
		else $error("operand forward not a move");
	result_move_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ5
		o_result_fwd |-> $past(i_sec.op) == OP_MOVE) else $error("result forward not a move");
	bypass_pair_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ7
		o_bypass |-> $past(i_pri.dst_mem && i_sec.src_mem && i_pri.mem_addr == i_sec.mem_addr))
		else $error("bypass without store-load pair");
	flush_target_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ17
		o_flush |-> o_next_pc == ($past(i_res_taken) ? $past(i_res_target)
		: $past(i_res_pc) + FETCH_STEP)) else $error("flush refetch address wrong");
	flush_stage_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ15
		o_flush |-> o_resolve_wb == $past(i_res_flags_paired))
		else $error("resolve stage wrong");
	hold_refuse_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ19
		state == HOLD |=> !o_flush) else $error("flush during hold");
	miss_seq_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ13
		(i_fetch_op == OP_BRCND && !tif.hit && !redirect)
		|=> (o_next_pc == $past(i_fetch_pc) + FETCH_STEP && !o_pred_taken))
		else $error("miss not sequential");
	cond_hit_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ12
		(i_fetch_op == OP_BRCND && tif.hit && !redirect)
		|=> o_pred_taken == $past(tif.hit_hist[1])) else $error("history not followed");
	alt_path_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ18
		(i_fetch_op == OP_BRCND && !redirect) |=> o_alt_pc == (o_pred_taken
		? $past(i_fetch_pc) + FETCH_STEP : $past(tif.hit ? tif.hit_target : i_fetch_target)))
		else $error("alternate path wrong");
	uncond_hit_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ11
		(i_fetch_op == OP_BRUNC && tif.hit && !redirect)
		|=> (o_next_pc == $past(tif.hit_target) && o_pred_taken))
		else $error("jump not redirected");
	call_push_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ21
		i_fetch_op == OP_CALL |=> stack[0] == $past(i_fetch_pc) + FETCH_STEP)
		else $error("call not pushed");
	ret_pop_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ20
		(i_fetch_op == OP_RET && depth != 4'h0 && !redirect) |=> o_next_pc == $past(stack[0]))
		else $error("return not from stack");
	ret_empty_a: assert property (@(posedge i_clk) disable iff (i_rst) // RQ25
		(i_fetch_op == OP_RET && depth == 4'h0 && !tif.hit && !redirect)
		|=> o_next_pc == $past(i_fetch_pc) + FETCH_STEP)
		else $error("empty return fallback wrong");
	cov_opfwd: cover property (@(posedge i_clk) o_operand_fwd);
	cov_resfwd: cover property (@(posedge i_clk) o_result_fwd);
	cov_bypass: cover property (@(posedge i_clk) o_bypass);
	cov_flush: cover property (@(posedge i_clk) o_flush);
	cov_wbflush: cover property (@(posedge i_clk) o_flush && o_resolve_wb);
endmodule
`default_nettype wire

// File: testbench/fetch_cache_model.sv
// Stand-in for the fetch unit and data cache beside the dual-pipe control block
`timescale 1ns/1ps
`default_nettype none
module fetch_cache_model #(
	parameter logic [31:0] UNCACHED_BASE = 32'h8000_0000
) (
	input  wire logic                             i_clk,
	input  wire logic                             i_req,
	input  wire pipe_ctrl_pkg::op_e               i_op,
	input  wire logic [pipe_ctrl_pkg::ADDR_W-1:0] i_pc,
	input  wire logic [pipe_ctrl_pkg::ADDR_W-1:0] i_target,
	input  wire logic [pipe_ctrl_pkg::ADDR_W-1:0] i_mem_addr,
	output var  pipe_ctrl_pkg::op_e               o_op,
	output logic [pipe_ctrl_pkg::ADDR_W-1:0]      o_pc,
	output logic [pipe_ctrl_pkg::ADDR_W-1:0]      o_target,
	output logic                                  o_cacheable
);
	import pipe_ctrl_pkg::*;
	logic [ADDR_W-1:0] idle_pc = '0;
	logic [ADDR_W-1:0] idle_target = '0;

	// Idle lines toggle each cycle so a stale value never passes for a request
	always @(posedge i_clk) begin
		idle_pc <= ~o_pc;
		idle_target <= ~o_target;
	end

	// Requests pass straight through; between them no branch is offered
	always_comb begin
		o_op = i_req ? i_op : OP_NONE;
		o_pc = i_req ? i_pc : idle_pc;
		o_target = i_req ? i_target : idle_target;
	end

	// Cacheable below the uncached window
	assign o_cacheable = (i_mem_addr < UNCACHED_BASE);
endmodule
`default_nettype wire

// File: testbench/dual_pipe_forwarding_branch_predict_bench.sv
// Self-checking bench for the dual-pipe hazard and branch control block
`timescale 1ns/1ps
`default_nettype none
module dual_pipe_forwarding_branch_predict_bench;
	import pipe_ctrl_pkg::*;
	localparam logic [31:0] P = 32'h0000_1040;
	localparam logic [31:0] T = 32'h0000_2000;
	localparam logic [31:0] Q = 32'h0000_3080;
	localparam logic [31:0] T2 = 32'h0000_4000;
	localparam logic [31:0] C = 32'h0000_6000;
	localparam logic [31:0] R = 32'h0000_7100;
	localparam logic [31:0] A = 32'h0000_0200;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	instr_s      pri = '0;
	instr_s      sec = '0;
	logic        req = 1'b0;
	op_e         f_op = OP_NONE;
	logic [31:0] f_pc = '0;
	logic [31:0] f_tgt = '0;
	logic        r_valid = 1'b0;
	logic [31:0] r_pc = '0;
	logic        r_taken = 1'b0;
	logic [31:0] r_tgt = '0;
	logic        r_pred = 1'b0;
	logic        r_paired = 1'b0;
	op_e         m_op;
	logic [31:0] m_pc;
	logic [31:0] m_tgt;
	logic        m_cache;
	logic        ofwd;
	logic        rfwd;
	logic        byp;
	logic        stall;
	logic        secbr;
	logic [31:0] npc;
	logic [31:0] apc;
	logic        pred;
	logic        flush;
	logic        wb;
	logic        hold;
	int          fail_count = 0;
	int          n_tests = 0;

	// Core clock, 5 ns period
	always #2.5 i_clk = ~i_clk;

	fetch_cache_model model_u (.i_clk(i_clk), .i_req(req), .i_op(f_op), .i_pc(f_pc),
		.i_target(f_tgt), .i_mem_addr(pri.mem_addr), .o_op(m_op), .o_pc(m_pc),
		.o_target(m_tgt), .o_cacheable(m_cache));

	dual_pipe_ctrl dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_pri(pri), .i_sec(sec),
		.i_cacheable(m_cache), .i_fetch_pc(m_pc), .i_fetch_op(m_op),
		.i_fetch_target(m_tgt), .i_res_valid(r_valid), .i_res_pc(r_pc),
		.i_res_taken(r_taken), .i_res_target(r_tgt), .i_res_predicted(r_pred),
		.i_res_flags_paired(r_paired), .o_operand_fwd(ofwd), .o_result_fwd(rfwd),
		.o_bypass(byp), .o_sec_stall(stall), .o_sec_is_branch(secbr), .o_next_pc(npc),
		.o_alt_pc(apc), .o_pred_taken(pred), .o_flush(flush), .o_resolve_wb(wb),
		.o_fetch_hold(hold));

	// One comparison, reported at once on mismatch
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Verdict and end of run
	task automatic conclude();
		if (fail_count == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Builds one valid issued instruction
	function automatic instr_s mk(op_e op, logic sm, logic dm, logic [4:0] sr,
			logic [4:0] dr, logic [31:0] a, size_e ss, size_e ds);
		return '{1'b1, op, sm, dm, sr, dr, a, ss, ds, 1'b0};
	endfunction

	// Presents a pair for one cycle and checks the hazard flags
	task automatic pair(instr_s p, instr_s s, logic fo, logic ro, logic bp, logic st);
		pri = p;
		sec = s;
		@(negedge i_clk);
		chk("operand_fwd", fo, ofwd);
		chk("result_fwd", ro, rfwd);
		chk("bypass", bp, byp);
		chk("sec_stall", st, stall);
		chk("sec_is_branch", s.valid && s.op == OP_BRCND, secbr);
	endtask

	// Forwarding cases, plain and refused
	task automatic t_forward();
		pair(mk(OP_MOVE, 1, 0, 0, 3, A, SZ_32, SZ_32), mk(OP_ALU, 0, 0, 3, 7, 0, SZ_32, SZ_32), 1, 0, 0, 0);
		pair(mk(OP_MOVE, 1, 0, 0, 3, A, SZ_32, SZ_16), mk(OP_ALU, 0, 0, 3, 7, 0, SZ_32, SZ_32), 0, 0, 0, 0);
		pair(mk(OP_MOVE, 0, 1, 2, 0, A, SZ_32, SZ_32), mk(OP_ALU, 1, 0, 9, 7, A, SZ_32, SZ_32), 1, 0, 0, 0);
		pair(mk(OP_ALU, 0, 0, 1, 3, 0, SZ_32, SZ_32), mk(OP_ALU, 0, 0, 3, 7, 0, SZ_32, SZ_32), 0, 0, 0, 0);
		pair(mk(OP_ALU, 0, 0, 1, 4, 0, SZ_32, SZ_32), mk(OP_MOVE, 0, 0, 4, 8, 0, SZ_32, SZ_32), 0, 1, 0, 0);
		pair(mk(OP_ALU, 0, 0, 1, 4, 0, SZ_32, SZ_32), mk(OP_BRCND, 0, 0, 5, 8, 0, SZ_32, SZ_32), 0, 0, 0, 1);
	endtask

	// Store then load: bypass with one stall, none when uncached
	task automatic t_bypass();
		pair(mk(OP_ALU, 0, 1, 1, 0, A, SZ_32, SZ_32), mk(OP_ALU, 1, 0, 9, 7, A, SZ_32, SZ_32), 0, 0, 1, 1);
		pair(mk(OP_ALU, 0, 1, 1, 0, A, SZ_32, SZ_32), mk(OP_ALU, 1, 0, 9, 7, A, SZ_32, SZ_32), 0, 0, 1, 0);
		pair(mk(OP_ALU, 0, 1, 1, 0, 32'h9000_0000, SZ_32, SZ_32), mk(OP_ALU, 1, 0, 9, 7, 32'h9000_0000, SZ_32, SZ_32), 0, 0, 0, 0);
		pri = '0;
		sec = '0;
		@(negedge i_clk);
	endtask

	// One fetch request and its prediction
	task automatic fetch(op_e op, logic [31:0] pc, logic [31:0] t, logic [31:0] en, logic ep);
		req = 1'b1;
		f_op = op;
		f_pc = pc;
		f_tgt = t;
		@(negedge i_clk);
		req = 1'b0;
		chk("next_pc", en, npc);
		if (op == OP_BRCND) begin
			chk("pred_taken", ep, pred);
			chk("alt_pc", ep ? pc + FETCH_STEP : t, apc);
		end
		@(negedge i_clk);
	endtask

	// One resolution; eh is the expected hold length, zero when correct
	task automatic resolve(logic [31:0] pc, logic tk, logic [31:0] t, logic pd, logic pr, int eh);
		int n;
		r_valid = 1'b1;
		r_pc = pc;
		r_taken = tk;
		r_tgt = t;
		r_pred = pd;
		r_paired = pr;
		@(negedge i_clk);
		r_valid = 1'b0;
		n = 0;
		chk("flush", eh != 0, flush);
		if (eh != 0) begin
			chk("flush_pc", t, npc);
			chk("resolve_wb", pr, wb);
		end
		while (hold === 1'b1 && n < 12) begin
			n++;
			@(negedge i_clk);
		end
		chk("hold_cycles", eh, n);
		@(negedge i_clk);
	endtask

	// Miss, allocation, history walk and recovery costs
	task automatic t_branch();
		fetch(OP_BRCND, P, T, P + FETCH_STEP, 0);
		resolve(P, 1, T, 0, 0, LAT_EXEC);
		fetch(OP_BRCND, P, T, T, 1);
		resolve(P, 1, T, 1, 0, 0);
		resolve(P, 0, P + FETCH_STEP, 1, 1, LAT_WBACK);
		fetch(OP_BRCND, P, T, T, 1);
		resolve(P, 0, P + FETCH_STEP, 1, 0, LAT_EXEC);
		fetch(OP_BRCND, P, T, P + FETCH_STEP, 0);
		resolve(Q, 1, T2, 0, 0, LAT_EXEC);
		fetch(OP_BRUNC, Q, T2, T2, 0);
	endtask

	// A second mispredict during the hold is ignored
	task automatic t_refuse();
		r_valid = 1'b1;
		r_pc = P;
		r_taken = 1'b1;
		r_tgt = T;
		r_pred = 1'b0;
		r_paired = 1'b0;
		@(negedge i_clk);
		r_tgt = T + 32'h0000_0100;
		@(negedge i_clk);
		r_valid = 1'b0;
		chk("flush_in_hold", 0, flush);
		chk("hold_in_hold", 1, hold);
		repeat (3) @(negedge i_clk);
		chk("hold_after", 0, hold);
	endtask

	// Nine calls overflow the stack; returns pop newest first, then fall back
	task automatic t_stack();
		req = 1'b1;
		f_op = OP_CALL;
		f_tgt = 32'h0000_7000;
		for (int i = 0; i < 9; i++) begin
			f_pc = C + 32'(16 * i);
			@(negedge i_clk);
		end
		req = 1'b0;
		@(negedge i_clk);
		for (int i = 8; i > 0; i--) begin
			fetch(OP_RET, R, 32'h0000_0000, C + 32'(16 * i) + FETCH_STEP, 0);
		end
		fetch(OP_RET, R, 32'h0000_0000, R + FETCH_STEP, 0);
	endtask

	// Main sequence
	initial begin
		repeat (16) @(negedge i_clk);
		i_rst = 1'b0;
		@(negedge i_clk);
		chk("flush_reset", 0, flush);
		chk("hold_reset", 0, hold);
		t_forward();
		t_bypass();
		t_branch();
		t_refuse();
		t_stack();
		conclude();
	end

	// Watchdog against a hang
	initial begin
		#100000;
		fail_count++;
		conclude();
	end
endmodule
`default_nettype wire
